// ==== shared/srh_consts.vh ====
// timing and geometry constants for the static memory host controller
`ifndef SRH_CONSTS_VH
`define SRH_CONSTS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SRH_ADDR_W 14
`define SRH_DEPTH 16384

// ----------------------------------------------------------------
// clock and timing, slowest grade, in ns
// ----------------------------------------------------------------
`define SRH_CLK_NS 100
`define SRH_ACCESS_NS 85
`define SRH_WRITE_STROBE_WIDTH_NS 45
`define SRH_ADDRESS_SETUP_TO_WRITE_END_NS 65
`define SRH_INPUT_SETUP_TO_WRITE_END_NS 35
`define SRH_CYCLE_PERIOD_NS 75
`define SRH_DESELECT_TO_FLOAT_NS 30

// least waits round up to whole cycles and never drop below this
`define SRH_MIN_CYC 1
// extra read cycles that cover the two-flop data synchroniser
`define SRH_SYNC_CYC 4'h2

`define SRH_CNT_W 4

`endif

// ==== rtl/srh_wait_timer.v ====
// down counter that measures a least wait in clock cycles
`timescale 1ns/1ns
`default_nettype none

module srh_wait_timer #(
    parameter W = 4
) (
    input wire clk,
    input wire srst,
    input wire load,
    input wire [W-1:0] count,
    output reg done
);

    reg [W-1:0] remain; // cycles still to wait

    // ------------------------------------------------------------
    // countdown; done is high once the loaded wait has elapsed
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            remain <= {W{1'b0}};
            done <= 1'b1;
        end else if (load) begin
            remain <= count;
            done <= (count == {W{1'b0}});
        end else if (remain != {W{1'b0}}) begin
            remain <= remain - {{(W-1){1'b0}}, 1'b1};
            done <= (remain == {{(W-1){1'b0}}, 1'b1});
        end
    end

endmodule
`default_nettype wire

// ==== rtl/srh_sram_host.v ====
// host-side controller for a 16k x 1 asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
`include "srh_consts.vh"

module srh_sram_host #(
    parameter ADDR_W = `SRH_ADDR_W
) (
    input wire clk,
    input wire srst,
    input wire req_valid,
    input wire req_write,
    input wire [ADDR_W-1:0] req_addr,
    input wire req_wdata,
    output reg req_ready,
    output reg rsp_valid,
    output reg rsp_rdata,
    output reg [ADDR_W-1:0] mem_addr,
    output reg mem_select_n,
    output reg mem_write_n,
    output reg mem_din,
    input wire mem_dout
);

    // ------------------------------------------------------------
    // least time in ns to whole clock cycles
    // ------------------------------------------------------------
    // rounding up keeps every wait at or above its least figure;
    // the cut to the counter width is deliberate, counts stay small
    function [`SRH_CNT_W-1:0] ns_to_cyc;
        input integer ns;
        integer whole;
        begin
            whole = (ns + `SRH_CLK_NS - 1) / `SRH_CLK_NS;
            if (whole < `SRH_MIN_CYC) begin
                whole = `SRH_MIN_CYC;
            end
            ns_to_cyc = whole[`SRH_CNT_W-1:0];
        end
    endfunction

    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam [`SRH_CNT_W-1:0] ACCESS_CYC = ns_to_cyc(`SRH_ACCESS_NS);
    localparam [`SRH_CNT_W-1:0] STROBE_CYC = ns_to_cyc(`SRH_WRITE_STROBE_WIDTH_NS);
    localparam [`SRH_CNT_W-1:0] GAP_CYC = ns_to_cyc(`SRH_CYCLE_PERIOD_NS);
    localparam [`SRH_CNT_W-1:0] FLOAT_CYC = ns_to_cyc(`SRH_DESELECT_TO_FLOAT_NS);
    localparam [`SRH_CNT_W-1:0] SYNC_CYC = `SRH_SYNC_CYC; // synchroniser allowance

    // ------------------------------------------------------------
    // one-hot states
    // ------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;  // bus parked, select high
    localparam [4:0] ST_RDACC = 5'h02; // read access running
    localparam [4:0] ST_WRSET = 5'h04; // address and data settle
    localparam [4:0] ST_WRPUL = 5'h08; // strobe low
    localparam [4:0] ST_GAP = 5'h10;   // recovery between cycles

    reg [4:0] state;
    reg [4:0] next_state;
    reg tmr_load;                // start a wait
    reg [`SRH_CNT_W-1:0] tmr_cnt; // length of that wait
    wire tmr_done;               // wait elapsed
    reg dout_s1;                 // first sync stage, feeds dout_s2 only
    reg dout_s2;                 // synchronised read data

    // ------------------------------------------------------------
    // read data comes from an asynchronous part: two flops first
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            dout_s1 <= 1'b0;
            dout_s2 <= 1'b0;
        end else begin
            dout_s1 <= mem_dout;
            dout_s2 <= dout_s1;
        end
    end

    srh_wait_timer #(
        .W(`SRH_CNT_W)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .load(tmr_load),
        .count(tmr_cnt),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_cnt = {`SRH_CNT_W{1'b0}};
        case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    tmr_load = 1'b1;
                    if (req_write) begin
                        // address and data lead the strobe by a full cycle
                        next_state = ST_WRSET;
                        tmr_cnt = {`SRH_CNT_W{1'b0}};
                    end else begin
                        next_state = ST_RDACC;
                        // two extra cycles cover the data synchroniser
                        tmr_cnt = ACCESS_CYC + SYNC_CYC;
                    end
                end
            end
            ST_RDACC: begin
                if (tmr_done) begin
                    next_state = ST_GAP;
                    tmr_load = 1'b1;
                    tmr_cnt = FLOAT_CYC;
                end
            end
            ST_WRSET: begin
                next_state = ST_WRPUL;
                tmr_load = 1'b1;
                tmr_cnt = STROBE_CYC;
            end
            ST_WRPUL: begin
                if (tmr_done) begin
                    next_state = ST_GAP;
                    tmr_load = 1'b1;
                    tmr_cnt = GAP_CYC;
                end
            end
            ST_GAP: begin
                if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register and pin drive, all outputs from flops
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_select_n <= 1'b1;
            mem_write_n <= 1'b1;
            mem_din <= 1'b0;
        end else begin
            state <= next_state;
            rsp_valid <= 1'b0;
            req_ready <= (next_state == ST_IDLE);
            case (state)
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        // controls are high here, so the address may move
                        mem_addr <= req_addr;
                        mem_din <= req_wdata;
                        // reads select at once; writes wait a cycle
                        mem_select_n <= req_write;
                    end
                end
                ST_RDACC: begin
                    if (tmr_done) begin
                        // data taken unchanged, no inversion
                        rsp_rdata <= dout_s2;
                        rsp_valid <= 1'b1;
                        mem_select_n <= 1'b1;
                    end
                end
                ST_WRSET: begin
                    // both low together opens the write
                    mem_select_n <= 1'b0;
                    mem_write_n <= 1'b0;
                end
                ST_WRPUL: begin
                    if (tmr_done) begin
                        // both rise on the same edge; address holds after
                        mem_write_n <= 1'b1;
                        mem_select_n <= 1'b1;
                        rsp_valid <= 1'b1;
                    end
                end
                ST_GAP: begin
                    mem_select_n <= 1'b1;
                    mem_write_n <= 1'b1;
                end
                default: begin
                    mem_select_n <= 1'b1;
                    mem_write_n <= 1'b1;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== verification/srh_sram_host_props.sv ====
// timing checker on the pins of the static memory host controller
`timescale 1ns/1ns
`default_nettype none
module srh_sram_host_props #(
    parameter ADDR_W = 14
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_select_n,
    input wire logic mem_write_n,
    input wire logic mem_din
);
    // ----------------------------------------------------------------
    // one clock domain: every property below uses this clock and reset
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // a taken request puts its address on the pins next cycle
    property p_addr_taken;
        req_valid && req_ready |=> mem_addr == $past(req_addr);
    endproperty
    a_addr_taken: assert property (p_addr_taken) else $error("address not forwarded");
    property p_read_walk;
        req_valid && req_ready && !req_write |=>
            (!mem_select_n && mem_write_n)[*4] ##1 (rsp_valid && mem_select_n);
    endproperty
    a_read_walk: assert property (p_read_walk) else $error("read cycle malformed");
    property p_write_width;
        $fell(mem_write_n) |=> !mem_write_n && !mem_select_n;
    endproperty
    a_write_width: assert property (p_write_width) else $error("strobe too short");
    property p_addr_setup;
        $rose(mem_write_n) |-> $past(mem_addr, 1) == $past(mem_addr, 2);
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("address setup short");
    property p_din_setup;
        $rose(mem_write_n) |-> $past(mem_din, 1) == $past(mem_din, 2);
    endproperty
    a_din_setup: assert property (p_din_setup) else $error("input bit setup short");
    // select and strobe end the write together, and the done pulse goes with them
    property p_end_together;
        $rose(mem_write_n) |-> $rose(mem_select_n) && rsp_valid;
    endproperty
    a_end_together: assert property (p_end_together) else $error("write end split");
    property p_space;
        $rose(mem_write_n) |=> mem_write_n;
    endproperty
    a_space: assert property (p_space) else $error("writes too close");
    property p_addr_quiet;
        $changed(mem_addr) |-> mem_select_n || mem_write_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("address moved mid write");
    // ----------------------------------------------------------------
    // covers: a full read, a write end, a write taken
    // ----------------------------------------------------------------
    // a plain sequence, so a vacuous pass of the read walk is not counted
    c_read: cover property (req_valid && req_ready && !req_write ##5 rsp_valid);
    c_write: cover property ($rose(mem_write_n));
    c_take: cover property (req_valid && req_ready && req_write);
endmodule
bind srh_sram_host srh_sram_host_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
    .mem_select_n(mem_select_n), .mem_write_n(mem_write_n), .mem_din(mem_din));
`default_nettype wire

// ==== verification/srh_mem_model.sv ====
// behavioural 16k x 1 asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
module srh_mem_model #(
    parameter ACC_NS = 85
) (
    input wire logic [13:0] mem_addr,
    input wire logic mem_select_n,
    input wire logic mem_write_n,
    input wire logic mem_din,
    output var logic mem_dout
);
    logic store [0:16383]; // one bit per location
    initial mem_dout = 1'b0;
    // written only in the overlap of both lows, so idle pins leave it alone
    always @(mem_select_n, mem_write_n, mem_addr, mem_din) begin
        if (!mem_select_n && !mem_write_n) begin
            store[mem_addr] = mem_din;
        end
    end
    // data lags a full access; the old bit lingers meanwhile; power state not visible
    always @(mem_addr, mem_select_n, mem_write_n) begin
        if (!mem_select_n && mem_write_n) begin
            mem_dout <= #ACC_NS store[mem_addr];
        end else begin
            mem_dout <= ~mem_dout; // floating: never a stale value
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the static memory host controller
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [13:0] req_addr = 14'h0000;
    logic req_wdata = 1'b0;
    logic req_ready, rsp_valid, rsp_rdata, mem_select_n, mem_write_n, mem_din, mem_dout;
    logic [13:0] mem_addr;
    logic q;
    integer fails = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    initial forever #50 clk = ~clk;
    srh_sram_host uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
        .mem_select_n(mem_select_n), .mem_write_n(mem_write_n), .mem_din(mem_din),
        .mem_dout(mem_dout));
    srh_mem_model mem (.mem_addr(mem_addr), .mem_select_n(mem_select_n),
        .mem_write_n(mem_write_n), .mem_din(mem_din), .mem_dout(mem_dout));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one request; latency is fixed, so it is measured on every call
    task automatic req(input logic w, input logic [13:0] a, input logic d, output logic r);
        integer n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1 req_valid = 1'b0;
        n = 1;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        check("latency", n, w ? 32'h4 : 32'h5);
        r = rsp_rdata;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_edges;
        logic [13:0] a [4] = '{14'h0000, 14'h0001, 14'h3FFE, 14'h3FFF};
        for (int i = 0; i < 4; i++) req(1'b1, a[i], i[0], q);
        for (int i = 0; i < 4; i++) begin
            req(1'b0, a[i], 1'b0, q);
            check("edge rdata", q, i[0]);
        end
        $display("edge addresses done");
    endtask
    task automatic t_overwrite;
        req(1'b1, 14'h3FFE, 1'b1, q);
        req(1'b1, 14'h3FFF, 1'b0, q);
        req(1'b0, 14'h3FFE, 1'b0, q);
        check("rewritten bit", q, 1);
        req(1'b0, 14'h0001, 1'b0, q);
        check("neighbour bit", q, 1);
        $display("overwrite done");
    endtask
    // reset mid-run with the request lines wiggling, then the old bit must survive
    task automatic t_reset_mid;
        req(1'b1, 14'h1234, 1'b1, q);
        req_addr = 14'h2AAA;
        srst = 1'b1;
        @(posedge clk);
        #1 check("select in reset", mem_select_n, 1);
        check("ready in reset", req_ready, 0);
        srst = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1 req_wdata = ~req_wdata;
            check("idle select", mem_select_n, 1);
        end
        req(1'b0, 14'h1234, 1'b0, q);
        check("kept bit", q, 1);
        $display("mid reset done");
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            fails = fails + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        t_edges;
        t_overwrite;
        t_reset_mid;
        give_verdict;
    end
endmodule
`default_nettype wire
